// ==== adcof_output_status.v ====
/*
 * Output framing and status logic of a twelve-bit multi-channel converter:
 * parallel or double-data-rate output formatting, first-channel marker,
 * overrange flag, calibration-done flag, reset pin and master/follower
 * synchronization. Registers sit behind a classic Wishbone slave.
 * Assumes samples arrive from the core on clk_i; reset pin, follower select,
 * sync input and address pins are asynchronous and are synchronised here.
 */
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "adcof_defines.vh"

module adcof_output_status #(
  parameter DW = 12,
  parameter HALF_CYCLES = `ADCOF_HALF_CYCLES,
  parameter CAL_CYCLES = `ADCOF_CAL_CYCLES
) (
  // system
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [8:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  // samples from the conversion core
  input wire [DW-1:0] sample_i,
  input wire [2:0] sample_chan_i,
  input wire sample_valid_i,
  input wire sample_ovr_i,
  input wire ovr_early_i,
  // device pins, asynchronous
  input wire reset_n_pin_i,
  input wire follower_sel_i,
  input wire serial_id_bit_low_i,
  input wire serial_id_bit_high_i,
  input wire sync_i,
  // synchronization pin drive
  output reg sync_o,
  output wire sync_oe_o,
  // output pins
  output reg [DW-1:0] data_o,
  output reg [1:0] marker_ovr_o,
  output reg output_data_clock_p_o,
  output reg output_data_clock_n_o,
  output reg cal_done_o,
  output reg [2:0] factory_probe_outputs_o
);

  localparam [7:0] HALF_LAST = HALF_CYCLES[7:0] - 8'h01;
  localparam [15:0] CAL_LAST = CAL_CYCLES[15:0] - 16'h0001;
  localparam NPAIR = DW / 2;

  // calibration states, one-hot
  localparam [2:0] CS_RESET = 3'b001;
  localparam [2:0] CS_CAL = 3'b010;
  localparam [2:0] CS_DONE = 3'b100;

  // byte address to register index; used by read and write decode
  function [7:0] reg_index;
    input [8:0] adr;
    begin
      reg_index = {1'b0, adr[8:2]};
    end
  endfunction

  // two-flop synchronisers for the asynchronous pins, plus the last
  // synchronised reset and sync levels; edges come from the second flop only
  reg [4:0] pin_meta_reg;
  reg [4:0] pin_sync_reg;
  reg reset_pin_last_reg;
  reg sync_last_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
      reset_pin_last_reg <= 1'b0;
      sync_last_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {serial_id_bit_high_i, serial_id_bit_low_i, sync_i,
                       follower_sel_i, reset_n_pin_i};
      pin_sync_reg <= pin_meta_reg;
      reset_pin_last_reg <= pin_sync_reg[0];
      sync_last_reg <= pin_sync_reg[2];
    end
  end
  wire reset_pin_s = pin_sync_reg[0];
  wire follower_s = pin_sync_reg[1];
  wire sync_in_s = pin_sync_reg[2];
  // [RULE_15] reset while pin low
  wire in_reset = rst_i | ~reset_pin_s;
  // [RULE_16] rising edge restarts
  wire pin_rise = reset_pin_s & ~reset_pin_last_reg;

  // registers
  reg [7:0] ctrl_reg;
  reg [7:0] dspp_reg;
  reg [7:0] order_reg;
  reg [7:0] phase_reg;
  reg [11:0] dpol_reg;
  reg [7:0] spol_reg;
  reg [7:0] dll_reg;
  reg ack_reg;

  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wb_wr = wb_req & wb_we_i;
  wire [7:0] widx = reg_index(wb_adr_i);
  wire soft_reset = wb_wr & wb_sel_i[0] & (widx == `ADCOF_IDX_CTRL) &
                    wb_dat_i[`ADCOF_CTRL_SOFTRST];
  // soft reset restores defaults as the pin does, but reruns calibration only once it is done
  wire restart = pin_rise | soft_reset;

  // register writes; defaults return in reset and on any restart
  always @(posedge clk_i) begin
    // [RULE_16] defaults restored
    if (in_reset | restart) begin
      ctrl_reg <= `ADCOF_RST_CTRL;
      dspp_reg <= `ADCOF_RST_DSPP;
      order_reg <= `ADCOF_RST_ORDER;
      phase_reg <= `ADCOF_RST_PHASE;
      dpol_reg <= `ADCOF_RST_DPOL;
      spol_reg <= `ADCOF_RST_SPOL;
      dll_reg <= `ADCOF_RST_DLL;
    end else if (wb_wr) begin
      case (widx)
        `ADCOF_IDX_CTRL: begin
          if (wb_sel_i[0]) ctrl_reg <= wb_dat_i[7:0];
        end
        `ADCOF_IDX_DSPP: begin
          if (wb_sel_i[0]) dspp_reg <= wb_dat_i[7:0];
        end
        `ADCOF_IDX_ORDER: begin
          if (wb_sel_i[0]) order_reg <= wb_dat_i[7:0];
        end
        `ADCOF_IDX_PHASE: begin
          if (wb_sel_i[0]) phase_reg <= wb_dat_i[7:0];
        end
        `ADCOF_IDX_DPOL: begin
          if (wb_sel_i[0]) dpol_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) dpol_reg[11:8] <= wb_dat_i[11:8];
        end
        `ADCOF_IDX_SPOL: begin
          if (wb_sel_i[0]) spol_reg <= wb_dat_i[7:0];
        end
        `ADCOF_IDX_DLL: begin
          if (wb_sel_i[0]) dll_reg <= wb_dat_i[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // calibration sequencer
  reg [2:0] cal_state_reg;
  reg [15:0] cal_cnt_reg;
  always @(posedge clk_i) begin
    // [RULE_14] low during reset
    if (in_reset) begin
      cal_state_reg <= CS_RESET;
      cal_cnt_reg <= 16'h0000;
      cal_done_o <= 1'b0;
    end else begin
      case (cal_state_reg)
        CS_RESET: begin
          // [RULE_12] start first calibration
          cal_state_reg <= CS_CAL;
          cal_cnt_reg <= 16'h0000;
        end
        CS_CAL: begin
          if (cal_cnt_reg == CAL_LAST) begin
            cal_state_reg <= CS_DONE;
            cal_done_o <= 1'b1;
          end else begin
            cal_cnt_reg <= cal_cnt_reg + 16'h0001;
          end
        end
        CS_DONE: begin
          // [RULE_13] high until restart
          if (soft_reset) begin
            cal_state_reg <= CS_CAL;
            cal_cnt_reg <= 16'h0000;
            cal_done_o <= 1'b0;
          end
        end
        default: begin
          cal_state_reg <= CS_RESET;
          cal_done_o <= 1'b0;
        end
      endcase
    end
  end

  // mode decode
  wire ddr_mode = ctrl_reg[`ADCOF_CTRL_DDR];
  wire iq_mode = ctrl_reg[`ADCOF_CTRL_IQ];
  wire single_ch = ctrl_reg[`ADCOF_CTRL_NCH_HI:`ADCOF_CTRL_NCH_LO] == 3'h0;
  // [RULE_14] standby and shutdown freeze outputs, calibration flag held
  wire frozen = ctrl_reg[`ADCOF_CTRL_STANDBY] | ctrl_reg[`ADCOF_CTRL_SHDN];
  wire odd_first = order_reg[0];
  wire dspp_on = dspp_reg[0];

  // latest sample from the core
  reg [DW-1:0] hold_data_reg;
  reg [2:0] hold_chan_reg;
  reg hold_ovr_reg;
  always @(posedge clk_i) begin
    if (in_reset) begin
      hold_data_reg <= 12'h000;
      hold_chan_reg <= 3'h0;
      hold_ovr_reg <= 1'b0;
    end else if (sample_valid_i) begin
      hold_data_reg <= sample_i;
      hold_chan_reg <= sample_chan_i;
      // [RULE_03] overrange tracks detection
      hold_ovr_reg <= sample_ovr_i;
    end
  end

  // output clock divider; a follower realigns on the sync pin edge
  reg [7:0] half_cnt_reg;
  reg phase_hi_reg;
  wire sync_rise = sync_in_s & ~sync_last_reg;
  // [RULE_20] common word timing
  wire realign = follower_s & sync_rise;
  wire half_end = half_cnt_reg == HALF_LAST;
  wire word_start = half_end & ~phase_hi_reg;
  always @(posedge clk_i) begin
    if (in_reset | realign) begin
      half_cnt_reg <= 8'h00;
      phase_hi_reg <= 1'b0;
    end else if (!frozen) begin
      if (half_end) begin
        half_cnt_reg <= 8'h00;
        phase_hi_reg <= ~phase_hi_reg;
      end else begin
        half_cnt_reg <= half_cnt_reg + 8'h01;
      end
    end
  end

  // word capture at the start of each output clock high half
  reg [DW-1:0] word_reg;
  reg mark_reg;
  reg ovr_reg;
  always @(posedge clk_i) begin
    if (in_reset) begin
      word_reg <= 12'h000;
      mark_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else if (word_start & ~frozen) begin
      // [RULE_10] data polarity
      word_reg <= hold_data_reg ^ dpol_reg;
      // [RULE_06] single channel marker
      if (single_ch) begin
        mark_reg <= ~iq_mode;
      end else begin
        // [RULE_05] marker on first channel
        mark_reg <= hold_chan_reg == 3'h0;
      end
      ovr_reg <= hold_ovr_reg;
    end
  end

  // [RULE_04] early overrange with post-processing
  wire ovr_now = ovr_reg | (dspp_on & ovr_early_i);
  wire mark_pin = mark_reg ^ spol_reg[`ADCOF_SPOL_MARK];
  wire ovr_pin = ovr_now ^ spol_reg[`ADCOF_SPOL_OVR];
  wire next_hi = half_end ? ~phase_hi_reg : phase_hi_reg;

  // pin formatting for the coming cycle
  reg [DW-1:0] data_next;
  reg [1:0] mo_next;
  integer k;
  always @* begin
    // [RULE_22] all bits in parallel
    data_next = word_reg;
    mo_next = 2'b00;
    if (ddr_mode) begin
      // [RULE_07] two bits per pair
      for (k = 0; k < NPAIR; k = k + 1) begin
        // [RULE_08] even bits high half
        if (next_hi ^ odd_first) begin
          data_next[2*k+1] = word_reg[2*k];
        end else begin
          // [RULE_09] odd bits low half
          data_next[2*k+1] = word_reg[2*k+1];
        end
        data_next[2*k] = ~data_next[2*k+1];
      end
      // [RULE_02] marker high half, overrange low half
      mo_next[1] = next_hi ? mark_pin : ovr_pin;
      mo_next[0] = ~mo_next[1];
    end else begin
      // [RULE_01] marker negative, overrange positive
      mo_next[0] = mark_pin;
      mo_next[1] = ovr_pin;
    end
  end

  // output clock delay line; the tap sets clock phase against data
  reg [3:0] clk_line_reg;
  // [RULE_11] phase from three registers
  wire [1:0] tap = dspp_on ? phase_reg[1:0] : phase_reg[3:2];
  wire clk_tap = clk_line_reg[tap] ^ dll_reg[0];
  always @(posedge clk_i) begin
    if (in_reset) begin
      clk_line_reg <= 4'h0;
      data_o <= 12'h000;
      marker_ovr_o <= 2'b00;
      output_data_clock_p_o <= 1'b0;
      output_data_clock_n_o <= 1'b1;
    end else if (!frozen) begin
      clk_line_reg <= {clk_line_reg[2:0], next_hi};
      data_o <= data_next;
      marker_ovr_o <= mo_next;
      // [RULE_10] clock polarity
      output_data_clock_p_o <= clk_tap ^ spol_reg[`ADCOF_SPOL_CLK];
      output_data_clock_n_o <= ~(clk_tap ^ spol_reg[`ADCOF_SPOL_CLK]);
    end
  end

  // [RULE_19] master drives sync pin
  assign sync_oe_o = ~follower_s;

  // master emits a sync pulse with each word start; probes stay quiet
  always @(posedge clk_i) begin
    if (in_reset) begin
      sync_o <= 1'b0;
      factory_probe_outputs_o <= 3'h0;
    end else begin
      // [RULE_18] follower only listens
      sync_o <= ~follower_s & word_start & ~frozen;
      factory_probe_outputs_o <= 3'h0;
    end
  end

  // bus answer: one cycle after the request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_reg <= wb_req;
      if (wb_req & ~wb_we_i) begin
        case (widx)
          `ADCOF_IDX_CTRL: wb_dat_o <= {24'h000000, ctrl_reg};
          `ADCOF_IDX_DSPP: wb_dat_o <= {24'h000000, dspp_reg};
          `ADCOF_IDX_ORDER: wb_dat_o <= {24'h000000, order_reg};
          `ADCOF_IDX_PHASE: wb_dat_o <= {24'h000000, phase_reg};
          `ADCOF_IDX_DPOL: wb_dat_o <= {20'h00000, dpol_reg};
          `ADCOF_IDX_SPOL: wb_dat_o <= {24'h000000, spol_reg};
          `ADCOF_IDX_DLL: wb_dat_o <= {24'h000000, dll_reg};
          `ADCOF_IDX_STAT: wb_dat_o <= {26'h0000000, pin_sync_reg[4:3],
                                        reset_pin_s, follower_s,
                                        cal_state_reg[1], cal_done_o};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_reg;

endmodule // adcof_output_status
`default_nettype wire

// ==== adcof_defines.vh ====
/*
 * Constants of the converter output framing block: register indexes,
 * field positions, reset values and timing counts.
 * Assumes a 40 ns system clock; included by adcof_output_status.v.
 */
// Operation
// [RULE_01] parallel mode: marker on negative pin, overrange on positive pin
// [RULE_02] ddr mode: marker at clock rising edge, overrange at falling edge
// [RULE_03] overrange flag is high whenever input overrange is detected
// [RULE_04] with post-processing on, overrange may lead its data word
// [RULE_05] marker low by default, high while first channel data is sent
// [RULE_06] single channel: marker stays high, except in i/q output mode
// [RULE_07] ddr mode: two data bits per pair, one per clock half
// [RULE_08] even-bit-first: even bits shown while output clock is high
// [RULE_09] even-bit-first: odd bits shown while output clock is low
// [RULE_10] output polarity inversion controlled by registers 0x65 and 0x68
// [RULE_11] output clock phase adjustable through registers 0x52, 0x64, 0x6D
// [RULE_12] calibration-done low after power-up until first calibration ends
// [RULE_13] calibration-done stays high until reset pin or soft reset
// [RULE_14] calibration-done low in reset, held in standby and shutdown
// [RULE_15] device in reset while reset pin low, normal while high
// [RULE_16] reset pin rise restores register defaults and starts calibration
// [RULE_17] host keeps address select pins stable while chip select low
// [RULE_18] follower-select high: follower, synchronization pin is input
// [RULE_19] follower-select low: master, synchronization pin is output
// [RULE_20] master and followers share one sample clock via sync pin
// [RULE_21] board ties the two address select pins to fixed levels
// [RULE_22] parallel mode: twelve bits at once, output clock marks words
`ifndef ADCOF_DEFINES_VH
`define ADCOF_DEFINES_VH

// register indexes; byte address is four times the index
`define ADCOF_IDX_CTRL 8'h00
`define ADCOF_IDX_DSPP 8'h52
`define ADCOF_IDX_ORDER 8'h62
`define ADCOF_IDX_PHASE 8'h64
`define ADCOF_IDX_DPOL 8'h65
`define ADCOF_IDX_SPOL 8'h68
`define ADCOF_IDX_DLL 8'h6D
`define ADCOF_IDX_STAT 8'h70

// control register fields
`define ADCOF_CTRL_DDR 0
`define ADCOF_CTRL_IQ 1
`define ADCOF_CTRL_NCH_LO 2
`define ADCOF_CTRL_NCH_HI 4
`define ADCOF_CTRL_SOFTRST 5
`define ADCOF_CTRL_STANDBY 6
`define ADCOF_CTRL_SHDN 7

// signal polarity register fields
`define ADCOF_SPOL_CLK 0
`define ADCOF_SPOL_MARK 1
`define ADCOF_SPOL_OVR 2

// reset values
`define ADCOF_RST_CTRL 8'h00
`define ADCOF_RST_DSPP 8'h00
`define ADCOF_RST_ORDER 8'h00
`define ADCOF_RST_PHASE 8'h00
`define ADCOF_RST_DPOL 12'h000
`define ADCOF_RST_SPOL 8'h00
`define ADCOF_RST_DLL 8'h00

// timing
`define ADCOF_CLK_PERIOD_NS 40
`define ADCOF_CAL_TIME_NS 2560
`define ADCOF_HALF_CYCLES 2
`define ADCOF_CAL_CYCLES \
  ((`ADCOF_CAL_TIME_NS + `ADCOF_CLK_PERIOD_NS - 1) / `ADCOF_CLK_PERIOD_NS)

`endif

// ==== adcof_props.sv ====
/* checker of the output block: bus handshake, sync pin direction,
   calibration flag and output clock pair.
   Assumes a bind onto the ports of adcof_output_status. */
`timescale 1ns/1ns
`default_nettype none
module adcof_props #(
  parameter CAL_CYCLES = 64
) (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic reset_n_pin_i,
  input wire logic follower_sel_i,
  input wire logic sync_oe_o,
  input wire logic output_data_clock_p_o,
  input wire logic output_data_clock_n_o,
  input wire logic cal_done_o
);
  // the pin passes a synchroniser, so allow slack past the count
  localparam int CAL_HI = CAL_CYCLES + 8;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 9'h1FC |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_follower_input: assert property (
    follower_sel_i [*4] |-> !sync_oe_o) else $error("follower drives sync");
  a_master_output: assert property (
    !follower_sel_i [*4] |-> sync_oe_o) else $error("master leaves sync");
  a_cal_low_reset: assert property (
    !reset_n_pin_i [*5] |-> !cal_done_o) else $error("cal flag in reset");
  a_cal_holds: assert property (
    cal_done_o && reset_n_pin_i && !wb_stb_i && !$past(wb_stb_i) &&
    !$past(wb_stb_i, 2) && !$past(wb_stb_i, 3) |=> cal_done_o)
    else $error("cal flag dropped by itself");
  a_cal_restart: assert property (
    $rose(reset_n_pin_i) |-> !cal_done_o [*4] ##[1:CAL_HI] cal_done_o)
    else $error("calibration not rerun after reset pin");
  a_clk_compl: assert property (
    reset_n_pin_i [*6] |-> output_data_clock_p_o != output_data_clock_n_o)
    else $error("output clock pair not complementary");
endmodule // adcof_props
`default_nettype wire

// ==== adcof_capture_model.sv ====
/* capture receiver model: rebuilds {marker, overrange, data} words
   from the output pins. Assumes clock tap 0 and pins on clk_i. */
`timescale 1ns/1ns
`default_nettype none
module adcof_capture_model (
  // pins seen by the receiver
  input wire logic clk_i,
  input wire logic ddr_i,
  input wire logic clk_p_i,
  input wire logic [11:0] data_i,
  input wire logic [1:0] mo_i,
  // rebuilt word
  output logic [13:0] word_o,
  output logic valid_o
);
  logic p_q;
  logic mk_q;
  logic [5:0] even_q;
  integer k;
  // output clock edges found by sampling; in ddr mode only positive pins are used
  always @(posedge clk_i) begin
    p_q <= clk_p_i;
    valid_o <= 1'b0;
    if (!ddr_i && clk_p_i && !p_q) begin
      word_o <= {mo_i[0], mo_i[1], data_i};
      valid_o <= 1'b1;
    end
    if (ddr_i && clk_p_i && !p_q) begin
      for (k = 0; k < 6; k++) even_q[k] <= data_i[2*k+1];
      mk_q <= mo_i[1];
    end
    if (ddr_i && !clk_p_i && p_q) begin
      for (k = 0; k < 6; k++) begin
        word_o[2*k] <= even_q[k];
        word_o[2*k+1] <= data_i[2*k+1];
      end
      word_o[13:12] <= {mk_q, mo_i[1]};
      valid_o <= 1'b1;
    end
  end
endmodule // adcof_capture_model
`default_nettype wire

// ==== test_adcof_output_status.sv ====
/* testbench of the output block: registers, words in both modes,
   calibration flag, reset pin and sync pin direction.
   Assumes the capture model and checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("Error %0t: got %h want %h", $time, g, e); end end
module test_adcof_output_status;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, vld = 0, overrange_flag = 0;
  logic pin = 1, fol = 0, sync_i = 0, ddr = 0, ore = 0;
  logic [8:0] adr = 0;
  logic [31:0] dat = 0;
  logic [11:0] smp = 0;
  logic [2:0] ch = 0;
  wire [31:0] rd;
  wire ack, oe, ckp, cal, vw, sp;
  wire [2:0] fp;
  wire [11:0] dq;
  wire [1:0] mo;
  wire [13:0] w;
  logic [31:0] rq[$];
  logic [13:0] wq[$];
  logic [31:0] er;
  logic [13:0] ew;
  logic [7:0] ctl [6] = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h01, 8'h05};
  logic [2:0] chn [6] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h0, 3'h1};
  logic [5:0] mk = 6'b011001;
  int err_total = 0, samples_checked = 0, cyc_n = 0, i, sp_n = 0;
  adcof_output_status #(.CAL_CYCLES(4), .HALF_CYCLES(2)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(rd), .wb_ack_o(ack), .sample_i(smp), .sample_chan_i(ch),
    .sample_valid_i(vld), .sample_ovr_i(overrange_flag), .ovr_early_i(ore),
    .reset_n_pin_i(pin), .follower_sel_i(fol),
    // id pins held at fixed levels for the whole run
    .serial_id_bit_low_i(1'b1), .serial_id_bit_high_i(1'b0),
    .sync_i(sync_i), .sync_o(sp), .sync_oe_o(oe), .data_o(dq),
    .marker_ovr_o(mo), .output_data_clock_p_o(ckp),
    .output_data_clock_n_o(), .cal_done_o(cal),
    .factory_probe_outputs_o(fp));
  adcof_capture_model u_rx (.clk_i(clk_i), .ddr_i(ddr), .clk_p_i(ckp),
    .data_i(dq), .mo_i(mo), .word_o(w), .valid_o(vw));
  always #20 clk_i = ~clk_i;
  // 320 ns sync link while follower, plus the hang limit
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    sync_i <= fol & cyc_n[2];
    if (cyc_n > 20000) begin
      err_total++;
      finish_test;
    end
  end
  // results are matched against the oldest note of their kind
  always @(posedge clk_i) begin
    // sync pulses counted only when clean, so an unknown never counts
    sp_n <= sp_n + int'(sp === 1'b1);
    if (ack && !we && rq.size() > 0) begin
      er = rq.pop_front();
      `CHK(rd, er)
    end
    if (vw && wq.size() > 0) begin
      ew = wq.pop_front();
      `CHK(w, ew)
    end
  end
  task automatic bus(input logic wr, input logic [8:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= wr;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk_i);
  endtask
  task automatic rdq(input logic [8:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(0, a, 32'h0);
  endtask
  task automatic wait_cal(input logic lvl);
    for (i = 0; i < 100 && cal !== lvl; i++) @(posedge clk_i);
    `CHK(cal, lvl)
  endtask
  task automatic finish_test;
    if (rq.size() + wq.size() > 0) err_total++;
    $display("checked %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    void'($urandom(34964));
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wait_cal(1);
    rdq(9'h1FC, 32'h0);
    rdq(9'h188, 32'h0);
    rdq(9'h1C0, 32'h19);
    bus(1, 9'h194, 32'hABC);
    rdq(9'h194, 32'hABC);
    $display("registers done");
    // parallel and ddr, one and two channels, i/q in parallel only; inverted data throughout
    for (int t = 0; t < 6; t++) begin
      bus(1, 9'h000, {24'h0, ctl[t]});
      ddr <= ctl[t][0];
      smp <= 12'($urandom);
      ch <= chn[t];
      overrange_flag <= 1'($urandom);
      vld <= 1;
      repeat (16) @(posedge clk_i);
      wq.push_back({mk[t], overrange_flag, smp ^ 12'hABC});
      for (i = 0; i < 100 && wq.size() > 0; i++) @(posedge clk_i);
    end
    // post-processing on: live early detect must show as overrange
    bus(1, 9'h148, 32'h1);
    overrange_flag <= 0;
    ore <= 1;
    repeat (16) @(posedge clk_i);
    wq.push_back({1'b0, 1'b1, smp ^ 12'hABC});
    for (i = 0; i < 100 && wq.size() > 0; i++) @(posedge clk_i);
    ore <= 0;
    $display("words done");
    bus(1, 9'h000, 32'h40);
    repeat (10) @(posedge clk_i);
    `CHK(cal, 1'b1)
    bus(1, 9'h000, 32'h20);
    wait_cal(0);
    wait_cal(1);
    rdq(9'h194, 32'h0);
    $display("standby and soft reset done");
    bus(1, 9'h194, 32'h5);
    pin <= 0;
    repeat (8) @(posedge clk_i);
    `CHK(cal, 1'b0)
    bus(1, 9'h194, 32'h7);
    pin <= 1;
    wait_cal(1);
    rdq(9'h194, 32'h0);
    $display("reset pin done");
    fol <= 1;
    repeat (24) @(posedge clk_i);
    `CHK(oe, 1'b0)
    i = sp_n;
    repeat (8) @(posedge clk_i);
    `CHK(sp_n - i, 0)
    fol <= 0;
    repeat (6) @(posedge clk_i);
    `CHK(oe, 1'b1)
    // one pulse per word, a word every four cycles
    i = sp_n;
    repeat (16) @(posedge clk_i);
    `CHK(sp_n - i, 4)
    `CHK(fp, 3'h0)
    $display("sync pin done");
    finish_test;
  end
endmodule // test_adcof_output_status
bind adcof_output_status adcof_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .reset_n_pin_i, .follower_sel_i, .sync_oe_o,
  .output_data_clock_p_o, .output_data_clock_n_o, .cal_done_o);
`default_nettype wire
